/* core/lane_rx_pkg.sv */
// Constants shared by the receive lane crossbar and delay block
`default_nettype none
package lane_rx_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int NUM_PHYS = 8;
  localparam int NUM_LOGICAL = 4;
  localparam int SEL_W = 3;
  localparam int DELAY_W = 5;

  // Register offsets
  localparam logic [11:0] OFS_LINK_CTRL = 12'h300;
  localparam logic [11:0] OFS_FIXED_DELAY = 12'h304;
  localparam logic [11:0] OFS_VAR_DELAY = 12'h306;
  localparam logic [11:0] OFS_XBAR_FIRST = 12'h308;
  localparam logic [11:0] OFS_XBAR_SECOND = 12'h309;

  // Field positions
  localparam int LINK_EN_BIT = 0;
  localparam int DELAY_LSB = 0;
  localparam int SEL_LO_LSB = 0;
  localparam int SEL_HI_LSB = 3;

  // Reset values
  localparam logic [0:0] LINK_EN_RESET = 1'h0;
  localparam logic [4:0] FIXED_DELAY_RESET = 5'h00;
  localparam logic [4:0] VAR_DELAY_RESET = 5'h1F;
  localparam logic [2:0] LANE0_SRC_RESET = 3'h0;
  localparam logic [2:0] LANE1_SRC_RESET = 3'h1;
  localparam logic [2:0] LANE2_SRC_FIXED = 3'h2;
  localparam logic [2:0] LANE3_SRC_RESET = 3'h3;

  // Timing
  localparam int VAR_DELAY_MAX = 10;
  localparam int MULTIFRAME_CYCLES = 32;
  localparam int FIFO_DEPTH = 8;
endpackage : lane_rx_pkg
`default_nettype wire

/* core/lane_fifo.sv */
// Small FIFO with registered read stage and registered ready
`default_nettype none
module lane_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic in_ready;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_s;

  fifo_s state;
  fifo_s next_state;

  function automatic logic [PTR_W-1:0] ptr_step(input logic [PTR_W-1:0] p);
    ptr_step = (p == PTR_W'(DEPTH - 1)) ? '0 : PTR_W'(p + 1'h1);
  endfunction : ptr_step

  always_comb
  begin
    logic push;
    logic pop;
    push = 1'h0;
    pop = 1'h0;
    next_state = state;
    push = in_valid && state.in_ready;
    // Output stage refills whenever it is empty or being taken
    pop = (state.count != '0) && (!state.out_valid || out_ready);
    if (push)
    begin
      next_state.mem[state.wr_ptr] = in_data;
      next_state.wr_ptr = ptr_step(state.wr_ptr);
    end
    if (pop)
    begin
      next_state.out_data = state.mem[state.rd_ptr];
      next_state.rd_ptr = ptr_step(state.rd_ptr);
      next_state.out_valid = 1'h1;
    end
    else if (out_ready)
    begin
      next_state.out_valid = 1'h0;
    end
    next_state.count = CNT_W'(state.count + CNT_W'(push) - CNT_W'(pop));
    next_state.in_ready = (next_state.count < CNT_W'(DEPTH));
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= '0;
      state.in_ready <= 1'h1;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign in_ready = state.in_ready;
  assign out_valid = state.out_valid;
  assign out_data = state.out_data;
endmodule : lane_fifo
`default_nettype wire

/* core/lane_rx_xbar.sv */
// Receive lane crossbar, multiframe delays and release-timed lane buffer
`default_nettype none
// How it works
// - Five-bit fixed delay offsets the global multiframe boundary by that many cycles.
// - Five-bit variable delay picks where in the multiframe buffered words are released.
// - Variable delay field resets to all ones and must be reprogrammed first.
// - Lanes 0, 1 and 3 take the physical input numbered by their 3-bit selector; lane 2 is fixed to input 2.
// - First crossbar register: lane 1 in bits 5..3, lane 0 in bits 2..0.
// - Second crossbar register: lane 3 selector in bits 5..3, resets to three.
// - Lanes 0 and 1 reset to sources 0 and 1, a straight mapping.
module lane_rx_xbar #(
  parameter int LANE_W = 32,
  parameter int MF_CYCLES = lane_rx_pkg::MULTIFRAME_CYCLES,
  parameter int BUF_DEPTH = lane_rx_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [lane_rx_pkg::ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [lane_rx_pkg::DATA_W-1:0] reg_wdata,
  output logic [lane_rx_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rdata_valid,
  input wire logic [lane_rx_pkg::NUM_PHYS*LANE_W-1:0] physical_serial_input,
  input wire logic phys_valid,
  output logic phys_ready,
  output logic [lane_rx_pkg::NUM_LOGICAL*LANE_W-1:0] lane_data,
  output logic lane_valid,
  input wire logic lane_ready,
  output logic global_lmfc_pulse,
  output logic link_active
);
  localparam int DW = lane_rx_pkg::DATA_W;
  localparam int SW = lane_rx_pkg::SEL_W;
  localparam int DLW = lane_rx_pkg::DELAY_W;
  localparam int MFW = (MF_CYCLES > 1) ? $clog2(MF_CYCLES) : 1;
  localparam int BUS_W = lane_rx_pkg::NUM_LOGICAL * LANE_W;

  // Where the receive side stands in its bring-up
  typedef enum logic [1:0] {
    LINK_DOWN,
    WAITING,
    RELEASED
  } phase_e;

  typedef struct packed {
    logic link_enable;
    logic [DLW-1:0] global_multiframe_fixed_delay;
    logic [DLW-1:0] buffer_release_variable_delay;
    logic [SW-1:0] logical_lane_zero_source;
    logic [SW-1:0] logical_lane_one_source;
    logic [SW-1:0] logical_lane_three_source;
    logic [MFW-1:0] mf_count;
    phase_e phase;
    logic release_open;
    logic lmfc_pulse;
    logic [DW-1:0] rdata;
    logic rdata_valid;
    logic [BUS_W-1:0] out_data;
    logic out_valid;
  } xbar_s;

  xbar_s state;
  xbar_s next_state;

  logic [BUS_W-1:0] xbar_word;
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic buf_out_ready;
  logic [BUS_W-1:0] buf_out_data;

  // Multiframe positions wrap; sum of two settings may pass one multiframe
  function automatic logic [MFW-1:0] mf_wrap(input int unsigned pos);
    mf_wrap = MFW'(pos % MF_CYCLES);
  endfunction : mf_wrap

  function automatic logic [LANE_W-1:0] pick_lane(
    input logic [lane_rx_pkg::NUM_PHYS*LANE_W-1:0] phys,
    input logic [SW-1:0] sel
  );
    pick_lane = phys[sel*LANE_W +: LANE_W];
  endfunction : pick_lane

  function automatic logic [DW-1:0] pack_pair(
    input logic [SW-1:0] hi,
    input logic [SW-1:0] lo
  );
    pack_pair = '0;
    pack_pair[lane_rx_pkg::SEL_HI_LSB +: SW] = hi;
    pack_pair[lane_rx_pkg::SEL_LO_LSB +: SW] = lo;
  endfunction : pack_pair

  // Delay fields sit at the bottom of their byte; the bits above are reserved
  function automatic logic [DLW-1:0] delay_field(input logic [DW-1:0] wdata);
    delay_field = wdata[lane_rx_pkg::DELAY_LSB +: DLW];
  endfunction : delay_field

  function automatic logic [SW-1:0] sel_field(
    input logic [DW-1:0] wdata,
    input int lsb
  );
    sel_field = wdata[lsb +: SW];
  endfunction : sel_field

  // Crossbar: logical lane n sits at bits n*LANE_W upward
  always_comb
  begin
    xbar_word = '0;
    xbar_word[0*LANE_W +: LANE_W] =
      pick_lane(physical_serial_input, state.logical_lane_zero_source);
    xbar_word[1*LANE_W +: LANE_W] =
      pick_lane(physical_serial_input, state.logical_lane_one_source);
    xbar_word[2*LANE_W +: LANE_W] =
      pick_lane(physical_serial_input, lane_rx_pkg::LANE2_SRC_FIXED);
    xbar_word[3*LANE_W +: LANE_W] =
      pick_lane(physical_serial_input, state.logical_lane_three_source);
  end

  // Nothing enters the buffer until software brings the link up
  assign buf_in_valid = phys_valid && state.link_enable;
  // Buffered words leave only after the release point of the multiframe; dropping
  // the link stops the drain at once and the buffer keeps what it holds
  assign buf_out_ready = state.link_enable && state.release_open &&
    (!state.out_valid || lane_ready);

  lane_fifo #(
    .WIDTH(BUS_W),
    .DEPTH(BUF_DEPTH)
  ) u_lane_buffer (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(xbar_word),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  always_comb
  begin
    logic [MFW-1:0] release_pos;
    release_pos = '0;
    next_state = state;

    // Register writes; reserved bits are masked away
    if (reg_wr)
    begin
      case (reg_addr)
        lane_rx_pkg::OFS_LINK_CTRL:
        begin
          next_state.link_enable = reg_wdata[lane_rx_pkg::LINK_EN_BIT];
        end
        lane_rx_pkg::OFS_FIXED_DELAY:
        begin
          next_state.global_multiframe_fixed_delay =
            delay_field(reg_wdata);
        end
        lane_rx_pkg::OFS_VAR_DELAY:
        begin
          // Values above the limit are stored as written; no clamp is applied
          next_state.buffer_release_variable_delay =
            delay_field(reg_wdata);
        end
        lane_rx_pkg::OFS_XBAR_FIRST:
        begin
          next_state.logical_lane_one_source =
            sel_field(reg_wdata, lane_rx_pkg::SEL_HI_LSB);
          next_state.logical_lane_zero_source =
            sel_field(reg_wdata, lane_rx_pkg::SEL_LO_LSB);
        end
        lane_rx_pkg::OFS_XBAR_SECOND:
        begin
          next_state.logical_lane_three_source =
            sel_field(reg_wdata, lane_rx_pkg::SEL_HI_LSB);
        end
        default:
        begin
          next_state.link_enable = state.link_enable;
        end
      endcase
    end

    // Register reads answer one cycle later; unmapped offsets read zero
    next_state.rdata_valid = reg_rd;
    if (reg_rd)
    begin
      case (reg_addr)
        lane_rx_pkg::OFS_LINK_CTRL:
        begin
          next_state.rdata = '0;
          next_state.rdata[lane_rx_pkg::LINK_EN_BIT] = state.link_enable;
        end
        lane_rx_pkg::OFS_FIXED_DELAY:
        begin
          next_state.rdata = DW'(state.global_multiframe_fixed_delay);
        end
        lane_rx_pkg::OFS_VAR_DELAY:
        begin
          next_state.rdata = DW'(state.buffer_release_variable_delay);
        end
        lane_rx_pkg::OFS_XBAR_FIRST:
        begin
          next_state.rdata = pack_pair(state.logical_lane_one_source,
                                       state.logical_lane_zero_source);
        end
        lane_rx_pkg::OFS_XBAR_SECOND:
        begin
          // Lane 2 selector is not held here, its bits read zero
          next_state.rdata = pack_pair(state.logical_lane_three_source, '0);
        end
        default:
        begin
          next_state.rdata = '0;
        end
      endcase
    end

    // Multiframe counter runs only while the link is enabled
    if (state.link_enable)
    begin
      next_state.mf_count = mf_wrap(int'(state.mf_count) + 1);
    end
    else
    begin
      next_state.mf_count = '0;
    end

    // Global boundary lands one cycle after the counter reaches the fixed delay
    next_state.lmfc_pulse = state.link_enable &&
      (state.mf_count == mf_wrap(int'(state.global_multiframe_fixed_delay)));

    // Receive release point: variable delay counted from the global boundary
    release_pos = mf_wrap(int'(state.global_multiframe_fixed_delay) +
                          int'(state.buffer_release_variable_delay));
    // Once open the release stays open, so a late re-program cannot stall the link
    case (state.phase)
      LINK_DOWN,
      WAITING:
      begin
        if (!state.link_enable)
        begin
          next_state.phase = LINK_DOWN;
        end
        else if (state.mf_count == release_pos)
        begin
          next_state.phase = RELEASED;
        end
        else
        begin
          next_state.phase = WAITING;
        end
      end
      RELEASED:
      begin
        if (!state.link_enable)
        begin
          next_state.phase = LINK_DOWN;
        end
      end
      default:
      begin
        next_state.phase = LINK_DOWN;
      end
    endcase
    next_state.release_open = (next_state.phase == RELEASED);

    // Output stage; holds its word until the consumer takes it
    if (buf_out_valid && buf_out_ready)
    begin
      next_state.out_data = buf_out_data;
      next_state.out_valid = 1'h1;
    end
    else if (lane_ready)
    begin
      next_state.out_valid = 1'h0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= '0;
      state.link_enable <= lane_rx_pkg::LINK_EN_RESET[0];
      state.global_multiframe_fixed_delay <= lane_rx_pkg::FIXED_DELAY_RESET;
      state.buffer_release_variable_delay <= lane_rx_pkg::VAR_DELAY_RESET;
      state.logical_lane_zero_source <= lane_rx_pkg::LANE0_SRC_RESET;
      state.logical_lane_one_source <= lane_rx_pkg::LANE1_SRC_RESET;
      state.logical_lane_three_source <= lane_rx_pkg::LANE3_SRC_RESET;
      state.phase <= LINK_DOWN;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign reg_rdata = state.rdata;
  assign reg_rdata_valid = state.rdata_valid;
  // Ready comes from a flop inside the buffer
  assign phys_ready = buf_in_ready;
  assign lane_data = state.out_data;
  assign lane_valid = state.out_valid;
  assign global_lmfc_pulse = state.lmfc_pulse;
  assign link_active = state.release_open;
endmodule : lane_rx_xbar
`default_nettype wire

/* sim/lane_rx_xbar_sva.sv */
// Assertion checker on the lane crossbar ports
`default_nettype none
module lane_rx_xbar_sva #(
  parameter int LANE_W = 32
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [11:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rdata_valid,
  input wire logic [4*LANE_W-1:0] lane_data,
  input wire logic lane_valid,
  input wire logic lane_ready,
  input wire logic global_lmfc_pulse,
  input wire logic link_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  property p_rd_pulse; reg_rdata_valid == $past(reg_rd); endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read answer pulse wrong");
  property p_resv; reg_rdata_valid |-> reg_rdata[7:6] == 2'h0; endproperty
  a_resv: assert property (p_resv) else $error("reserved bits not zero");
  property p_fixed; reg_rd && reg_addr == 12'h304 |=> reg_rdata[7:5] == 3'h0; endproperty
  a_fixed: assert property (p_fixed) else $error("fixed delay wider than 5 bits");
  property p_xbar2; reg_rd && reg_addr == 12'h309 |=> reg_rdata[2:0] == 3'h0; endproperty
  a_xbar2: assert property (p_xbar2) else $error("second crossbar low bits set");
  property p_unmap;
    reg_rd && !(reg_addr inside {12'h300, 12'h304, 12'h306, 12'h308, 12'h309})
      |=> reg_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hold; lane_valid && !lane_ready |=> lane_valid && $stable(lane_data); endproperty
  a_hold: assert property (p_hold) else $error("lane word dropped while stalled");
  property p_gate; $rose(lane_valid) |-> link_active; endproperty
  a_gate: assert property (p_gate) else $error("word released before release point");
  property p_gap; global_lmfc_pulse |=> !global_lmfc_pulse [*8]; endproperty
  a_gap: assert property (p_gap) else $error("multiframe pulses too close");
endmodule : lane_rx_xbar_sva
bind lane_rx_xbar lane_rx_xbar_sva #(.LANE_W(LANE_W)) lane_rx_xbar_sva_i (
  .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .lane_data(lane_data),
  .lane_valid(lane_valid), .lane_ready(lane_ready),
  .global_lmfc_pulse(global_lmfc_pulse), .link_active(link_active));
`default_nettype wire

/* sim/lane_tx_model.sv */
// Transmitter model feeding eight physical lane words
`default_nettype none
module lane_tx_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic go,
  input wire logic phys_ready,
  output logic [255:0] physical_serial_input,
  output logic phys_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [23:0] st;
  logic taken;
  always @(posedge core_clk) taken <= phys_valid && phys_ready;
  // A word is held until taken; an idle bus inverts its data each cycle, so the last word returns every other cycle
  always @(negedge core_clk or negedge arst_n)
    if (!arst_n)
    begin
      phys_valid <= 1'b0;
      physical_serial_input <= '0;
      st <= 24'h000025;
    end
    else if (phys_valid && !taken)
      phys_valid <= 1'b1;
    else if (go)
    begin
      phys_valid <= 1'b1;
      st <= {st[22:0], st[23] ^ st[22] ^ st[21] ^ st[16]};
      for (int n = 0; n < 8; n++)
        physical_serial_input[n*32 +: 32] <= {st, 8'(n)};
    end
    else
    begin
      phys_valid <= 1'b0;
      physical_serial_input <= ~physical_serial_input;
    end
endmodule : lane_tx_model
`default_nettype wire

/* sim/lane_rx_xbar_tb.sv */
// Self-checking bench for the receive lane crossbar and delay block
`default_nettype none
module lane_rx_xbar_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, arst_n, reg_wr, reg_rd, phys_valid, phys_ready, lane_valid, lane_ready;
  logic global_lmfc_pulse, link_active, reg_rdata_valid, go, stall, linked;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [255:0] phys;
  logic [127:0] lane_data;
  logic [127:0] exp_q[$];
  logic [15:0] rnd = 16'h0025;
  logic [15:0] rr = 16'h0025;
  logic [2:0] s0, s1, s3;
  logic [4:0] fx, vr;
  int fail_count, total_checks, cyc, n;

  lane_rx_xbar #(.LANE_W(32), .MF_CYCLES(32), .BUF_DEPTH(8)) lane_rx_xbar_i (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rdata_valid(reg_rdata_valid), .physical_serial_input(phys),
    .phys_valid(phys_valid), .phys_ready(phys_ready), .lane_data(lane_data),
    .lane_valid(lane_valid), .lane_ready(lane_ready),
    .global_lmfc_pulse(global_lmfc_pulse), .link_active(link_active));
  lane_tx_model lane_tx_model_i (.core_clk(core_clk), .arst_n(arst_n), .go(go),
    .phys_ready(phys_ready), .physical_serial_input(phys), .phys_valid(phys_valid));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [127:0] mapped(input logic [255:0] p);
    return {p[s3*32 +: 32], p[64 +: 32], p[s1*32 +: 32], p[s0*32 +: 32]};
  endfunction : mapped

  task automatic check(input logic [127:0] seen, input logic [127:0] want);
    total_checks++;
    if (seen !== want)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, want);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : reg_write

  task automatic reg_expect(input logic [11:0] a, input logic [7:0] want);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    check(128'(reg_rdata_valid), 128'h1);
    check(128'(reg_rdata), 128'(want));
  endtask : reg_expect

  task automatic wait_for(input bit which);
    n = 0;
    while (!(which ? link_active : global_lmfc_pulse) && n < 60)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask : wait_for

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fail_count++;
      complete_run();
    end
    if (linked && phys_valid && phys_ready)
      exp_q.push_back(mapped(phys));
    if (lane_valid && lane_ready)
      check(lane_data, exp_q.size() > 0 ? exp_q.pop_front() : '1);
  end

  // Random back-pressure so the buffer both fills and drains
  always @(negedge core_clk)
  begin
    rr = lfsr(rr);
    lane_ready <= !stall && rr[0];
  end

  initial
  begin
    arst_n = 1'b0;
    {reg_wr, reg_rd, go, stall, linked, lane_ready} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    reg_expect(12'h300, 8'h00);
    reg_expect(12'h304, 8'h00);
    reg_expect(12'h306, 8'h1F);
    reg_expect(12'h308, 8'h08);
    reg_expect(12'h309, 8'h18);
    reg_expect(12'h305, 8'h00);
    reg_write(12'h304, 8'hFF);
    reg_expect(12'h304, 8'h1F);
    $display("test reset done");
    for (int k = 0; k < 4; k++)
    begin
      rnd = lfsr(rnd);
      {s3, s1, s0} = (k == 0) ? 9'h038 : rnd[8:0];
      fx = (k == 0) ? 5'd20 : 5'(rnd[15:11] % 21);
      vr = (k == 0) ? 5'd10 : 5'(rnd[12:9] % 11);
      reg_write(12'h308, {2'h3, s1, s0});
      reg_write(12'h309, {2'h3, s3, 3'h7});
      reg_write(12'h304, {3'h7, fx});
      reg_write(12'h306, {3'h7, vr});
      reg_expect(12'h308, {2'h0, s1, s0});
      reg_expect(12'h309, {2'h0, s3, 3'h0});
      reg_expect(12'h306, {3'h0, vr});
      reg_write(12'h300, 8'hFF);
      linked <= 1'b1;
      go <= 1'b1;
      wait_for(1'b0);
      // Boundary flop lands one cycle after the count meets the fixed delay
      check(128'(n), 128'(fx) + 128'h1);
      wait_for(1'b1);
      check(128'(n), 128'(vr));
      stall <= 1'b1;
      repeat (16) @(negedge core_clk);
      check(128'(phys_ready), 128'h0);
      stall <= 1'b0;
      repeat (20) @(negedge core_clk);
      go <= 1'b0;
      repeat (200) @(negedge core_clk);
      check(128'(exp_q.size()), 128'h0);
      reg_expect(12'h300, 8'h01);
      reg_write(12'h300, 8'h00);
      linked <= 1'b0;
      $display("test round %0d done", k);
    end
    complete_run();
  end
endmodule : lane_rx_xbar_tb
`default_nettype wire
